// ==== rtl/lbts_top.sv ====
// logic block table selection with output stage and apb registers
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module lbts_top
	import lbts_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// condition results, 2 bits each, block/slot/condition order
	input  wire logic [35:0] condResult,
	// lookup table units
	input  wire logic [5:0]  ltXSrcSet,
	input  wire logic [5:0]  ltRespValid,
	input  wire logic [95:0] ltYOut,
	// logic block outputs
	output logic [31:0]      lbOutValue,
	output logic [1:0]       lbNotAvail,
	output logic [5:0]       lbSelTable
);

	// ****************************************
	// configuration registers
	// ****************************************
	logic [1:0]  lbEnable;
	logic [10:0] operCfg  [0:1];
	logic [10:0] tableCfg [0:1];

	// ****************************************
	// apb decode
	// ****************************************
	wire        access   = psel & penable & pready;
	wire        wrAccess = access & pwrite;
	wire        hitEn    = (paddr == OFS_ENABLE);
	wire        hitOp1   = (paddr == OFS_OPER1);
	wire        hitOp2   = (paddr == OFS_OPER2);
	wire        hitTb1   = (paddr == OFS_TABLE1);
	wire        hitTb2   = (paddr == OFS_TABLE2);
	wire        hitSel   = (paddr == OFS_SELECT);
	wire        hitOut1  = (paddr == OFS_OUT1);
	wire        hitOut2  = (paddr == OFS_OUT2);
	wire        mapped   = hitEn | hitOp1 | hitOp2 | hitTb1 | hitTb2 |
	                       hitSel | hitOut1 | hitOut2;
	// status registers are read only; writing them is refused
	wire        roHit    = hitSel | hitOut1 | hitOut2;
	wire        badAcc   = !mapped | (pwrite & roHit);
	wire [31:0] selWord  = {21'h0, lbSelTable[5:3], 5'h0,
	                        lbSelTable[2:0]};
	wire [31:0] out1Word = {15'h0, lbNotAvail[0], lbOutValue[15:0]};
	wire [31:0] out2Word = {15'h0, lbNotAvail[1], lbOutValue[31:16]};
	wire [31:0] readMux  =
		hitEn   ? {30'h0, lbEnable} :
		hitOp1  ? {21'h0, operCfg[0]} :
		hitOp2  ? {21'h0, operCfg[1]} :
		hitTb1  ? {21'h0, tableCfg[0]} :
		hitTb2  ? {21'h0, tableCfg[1]} :
		hitSel  ? selWord :
		hitOut1 ? out1Word :
		hitOut2 ? out2Word : 32'h0;

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & penable & !pready;
			prdata  <= (psel & penable & !pready & !pwrite) ? readMux : 32'h0;
			pslverr <= psel & penable & !pready & badAcc;
		end
	end

	// ****************************************
	// register writes
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			lbEnable    <= RST_ENABLE;
			operCfg[0]  <= RST_OPER;
			operCfg[1]  <= RST_OPER;
			tableCfg[0] <= RST_TABLE1;
			tableCfg[1] <= RST_TABLE2;
		end else if (wrAccess) begin
			if (hitEn)
				lbEnable <= pwdata[1:0];
			if (hitOp1)
				operCfg[0] <= pwdata[10:0];
			if (hitOp2)
				operCfg[1] <= pwdata[10:0];
			if (hitTb1)
				tableCfg[0] <= pwdata[10:0];
			if (hitTb2)
				tableCfg[1] <= pwdata[10:0];
		end
	end

	// ****************************************
	// slot evaluation
	// ****************************************
	logic [5:0] slotHit;
	logic [1:0] selSlot [0:1];
	logic [2:0] next_sel   [0:1];
	logic       next_na    [0:1];
	logic [15:0] next_out  [0:1];

	genvar s;
	generate
		for (s = 0; s < NUM_BLOCKS*NUM_SLOTS; s++) begin : g_slot
			lbts_slot_eval u_eval (
				.oper (operCfg[s/3][(s%3)*FIELD_STEP +: OP_W]),
				.cond (condResult[s*6 +: 6]),
				.hit  (slotHit[s])
			);
		end
	endgenerate

	// ****************************************
	// per-block selection and output stage
	// ****************************************
	genvar b;
	generate
		for (b = 0; b < NUM_BLOCKS; b++) begin : g_blk
			wire [2:0]  tblNum;
			wire        tblOk;
			wire [2:0]  tIdx;
			wire        avail;
			wire [15:0] yVal;

			lbts_block_sel u_sel (
				.slotHit (slotHit[b*3 +: 3]),
				.selSlot (selSlot[b])
			);

			assign tblNum = tableCfg[b][selSlot[b]*FIELD_STEP +: TBL_W];
			// out-of-range table numbers behave as an unconfigured table
			assign tblOk  = (tblNum != 3'h0) && (tblNum <= 3'h6);
			assign tIdx   = tblOk ? (tblNum - 3'h1) : 3'h0;
			assign avail  = tblOk & ltXSrcSet[tIdx] &
			                ltRespValid[tIdx];
			assign yVal   = ltYOut[{tIdx, 4'h0} +: YOUT_W];

			always_comb begin
				next_sel[b] = lbEnable[b] ? tblNum : 3'h0;
				next_na[b]  = !(lbEnable[b] & avail);
				if (lbEnable[b] & avail) begin
					// clamp keeps the value inside 0..100.0 percent
					next_out[b] = (yVal > PCT_FULL) ? PCT_FULL : yVal;
				end else begin
					next_out[b] = 16'h0;
				end
			end

			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					lbSelTable[b*3 +: 3]   <= 3'h0;
					lbNotAvail[b]          <= 1'b1;
					lbOutValue[b*16 +: 16] <= 16'h0;
				end else begin
					lbSelTable[b*3 +: 3]   <= next_sel[b];
					lbNotAvail[b]          <= next_na[b];
					lbOutValue[b*16 +: 16] <= next_out[b];
				end
			end
		end
	endgenerate

	// ****************************************
	// checks on block 1, reset values of both blocks and output range of both blocks
	// ****************************************
	wire [5:0] c1A = condResult[5:0];
	wire [2:0] op1A = operCfg[0][2:0];
	wire [2:0] op1B = operCfg[0][6:4];

	property p_reset_cfg;
		@(posedge sys_clk) disable iff (!rst_n)
		!$past(rst_n) |-> (operCfg[0] == RST_OPER) &&
			(operCfg[1] == RST_OPER) && (lbEnable == 2'h0);
	endproperty
	a_reset_cfg: assert property (p_reset_cfg)
		else $error("operator or enable reset value wrong");

	property p_reset_tbl;
		@(posedge sys_clk) disable iff (!rst_n)
		!$past(rst_n) |-> (tableCfg[0] == RST_TABLE1) &&
			(tableCfg[1] == RST_TABLE2);
	endproperty
	a_reset_tbl: assert property (p_reset_tbl)
		else $error("table map reset value wrong");

	property p_default_a;
		@(posedge sys_clk) disable iff (!rst_n)
		(lbEnable[0] && op1A == OP_DEFAULT) |=>
			lbSelTable[2:0] == $past(tableCfg[0][2:0]);
	endproperty
	a_default_a: assert property (p_default_a)
		else $error("default slot A not selected");

	property p_and_na;
		@(posedge sys_clk) disable iff (!rst_n)
		(lbEnable[0] && op1A == OP_AND3 && c1A[1:0] == COND_NA &&
			c1A[3:2] == COND_TRUE && c1A[5:4] == COND_NA) |=>
			lbSelTable[2:0] == $past(tableCfg[0][2:0]);
	endproperty
	a_and_na: assert property (p_and_na)
		else $error("n/a not treated as true under AND3");

	property p_and_err;
		@(posedge sys_clk) disable iff (!rst_n)
		(lbEnable[0] && op1A == OP_AND3 && c1A[1:0] == COND_ERROR &&
			op1B == OP_DEFAULT && tableCfg[0][6:4] != tableCfg[0][2:0]) |=>
			lbSelTable[2:0] == $past(tableCfg[0][6:4]);
	endproperty
	a_and_err: assert property (p_and_err)
		else $error("error condition did not skip to slot B");

	property p_or_na;
		@(posedge sys_clk) disable iff (!rst_n)
		(lbEnable[0] && op1A == OP_OR3 && c1A == 6'h3E &&
			op1B == OP_DEFAULT) |=>
			lbSelTable[2:0] == $past(tableCfg[0][6:4]);
	endproperty
	a_or_na: assert property (p_or_na)
		else $error("error or n/a selected under OR3");

	property p_fallback;
		@(posedge sys_clk) disable iff (!rst_n)
		(lbEnable[0] && slotHit[2:0] == 3'h0) |=>
			lbSelTable[2:0] == $past(tableCfg[0][2:0]);
	endproperty
	a_fallback: assert property (p_fallback)
		else $error("no hit did not fall back to slot A");

	property p_disabled;
		@(posedge sys_clk) disable iff (!rst_n)
		!lbEnable[0] |=> (lbSelTable[2:0] == 3'h0) && lbNotAvail[0] &&
			(lbOutValue[15:0] == 16'h0);
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("disabled block still selecting");

	property p_no_xsrc;
		@(posedge sys_clk) disable iff (!rst_n)
		(g_blk[0].tblOk && !ltXSrcSet[g_blk[0].tIdx]) |=> lbNotAvail[0];
	endproperty
	a_no_xsrc: assert property (p_no_xsrc)
		else $error("missing x source not flagged");

	property p_pass_y;
		@(posedge sys_clk) disable iff (!rst_n)
		(lbEnable[0] && g_blk[0].avail && g_blk[0].yVal <= PCT_FULL) |=>
			!lbNotAvail[0] && lbOutValue[15:0] == $past(g_blk[0].yVal);
	endproperty
	a_pass_y: assert property (p_pass_y)
		else $error("y output not passed through");

	property p_range;
		@(posedge sys_clk) disable iff (!rst_n)
		lbOutValue[15:0] <= PCT_FULL && lbOutValue[31:16] <= PCT_FULL;
	endproperty
	a_range: assert property (p_range)
		else $error("output above full scale");

	// ****************************************
	// checks on operators, block 2 and enables
	// ****************************************
	property p_and2_or;
		@(posedge sys_clk) disable iff (!rst_n)
		(lbEnable[0] && op1A == OP_AND2_OR && c1A[5:4] == COND_TRUE) |=>
			lbSelTable[2:0] == $past(tableCfg[0][2:0]);
	endproperty
	a_and2_or: assert property (p_and2_or)
		else $error("third true did not select under code 3");

	property p_or2_and;
		@(posedge sys_clk) disable iff (!rst_n)
		(lbEnable[0] && op1A == OP_OR2_AND && c1A[5:4] != COND_TRUE &&
			op1B == OP_DEFAULT && tableCfg[0][6:4] != tableCfg[0][2:0]) |=>
			lbSelTable[2:0] == $past(tableCfg[0][6:4]);
	endproperty
	a_or2_and: assert property (p_or2_and)
		else $error("code 4 selected without third true");

	// codes above 4 are stored but must never pick their slot
	property p_bad_code;
		@(posedge sys_clk) disable iff (!rst_n)
		(lbEnable[0] && op1A > OP_OR2_AND && op1B == OP_DEFAULT &&
			tableCfg[0][6:4] != tableCfg[0][2:0]) |=>
			lbSelTable[2:0] == $past(tableCfg[0][6:4]);
	endproperty
	a_bad_code: assert property (p_bad_code)
		else $error("undefined operator code selected slot A");

	property p_blk2_order;
		@(posedge sys_clk) disable iff (!rst_n)
		(lbEnable[1] && slotHit[5:3] == 3'h4) |=>
			lbSelTable[5:3] == $past(tableCfg[1][10:8]);
	endproperty
	a_blk2_order: assert property (p_blk2_order)
		else $error("block 2 slot C not chosen after A and B miss");

	property p_sel_blk2;
		@(posedge sys_clk) disable iff (!rst_n)
		lbEnable[1] |=> lbSelTable[5:3] == $past(g_blk[1].tblNum);
	endproperty
	a_sel_blk2: assert property (p_sel_blk2)
		else $error("block 2 selected table not published");

	property p_enable_wr;
		@(posedge sys_clk) disable iff (!rst_n)
		(wrAccess && hitEn) |=> lbEnable == $past(pwdata[1:0]);
	endproperty
	a_enable_wr: assert property (p_enable_wr)
		else $error("enable write not stored");

	property p_na_zero;
		@(posedge sys_clk) disable iff (!rst_n)
		(lbNotAvail[0] |-> lbOutValue[15:0] == 16'h0) and
			(lbNotAvail[1] |-> lbOutValue[31:16] == 16'h0);
	endproperty
	a_na_zero: assert property (p_na_zero)
		else $error("unavailable output not held at zero");

endmodule

// ==== rtl/lbts_pkg.sv ====
// constants shared by the logic block table selection design
package lbts_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int NUM_BLOCKS  = 2;
	localparam int NUM_SLOTS   = 3;
	localparam int NUM_TABLES  = 6;
	localparam int COND_W      = 2;
	localparam int OP_W        = 3;
	localparam int TBL_W       = 3;
	localparam int FIELD_STEP  = 4;
	localparam int YOUT_W      = 16;

	// ****************************************
	// condition result codes
	// ****************************************
	localparam logic [1:0] COND_FALSE = 2'h0;
	localparam logic [1:0] COND_TRUE  = 2'h1;
	localparam logic [1:0] COND_ERROR = 2'h2;
	localparam logic [1:0] COND_NA    = 2'h3;

	// ****************************************
	// slot combining operator codes
	// ****************************************
	localparam logic [2:0] OP_DEFAULT  = 3'h0;
	localparam logic [2:0] OP_AND3     = 3'h1;
	localparam logic [2:0] OP_OR3      = 3'h2;
	localparam logic [2:0] OP_AND2_OR  = 3'h3;
	localparam logic [2:0] OP_OR2_AND  = 3'h4;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_ENABLE  = 8'h00;
	localparam logic [7:0] OFS_OPER1   = 8'h04;
	localparam logic [7:0] OFS_OPER2   = 8'h08;
	localparam logic [7:0] OFS_TABLE1  = 8'h0C;
	localparam logic [7:0] OFS_TABLE2  = 8'h10;
	localparam logic [7:0] OFS_SELECT  = 8'h14;
	localparam logic [7:0] OFS_OUT1    = 8'h18;
	localparam logic [7:0] OFS_OUT2    = 8'h1C;

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int SEL_POS2   = 8;
	localparam int NA_POS     = 16;
	localparam logic [10:0] RST_OPER   = 11'h011;
	localparam logic [10:0] RST_TABLE1 = 11'h321;
	localparam logic [10:0] RST_TABLE2 = 11'h654;
	localparam logic [1:0]  RST_ENABLE = 2'h0;

	// output full scale in tenths of a percent
	localparam logic [15:0] PCT_FULL  = 16'h03E8;

endpackage

// ==== rtl/lbts_slot_eval.sv ====
// one slot: combines three condition results with its operator
`timescale 1ns/1ps
module lbts_slot_eval
	import lbts_pkg::*;
(
	// configuration
	input  wire logic [OP_W-1:0] oper,
	// condition results, first in the low bits
	input  wire logic [5:0]      cond,
	// result
	output logic                 hit
);
	wire c1True = (cond[1:0] == COND_TRUE);
	wire c2True = (cond[3:2] == COND_TRUE);
	wire c3True = (cond[5:4] == COND_TRUE);
	// not applicable passes the all-three AND as true
	wire c1Pass = c1True | (cond[1:0] == COND_NA);
	wire c2Pass = c2True | (cond[3:2] == COND_NA);
	wire c3Pass = c3True | (cond[5:4] == COND_NA);

	always_comb begin
		case (oper)
			OP_DEFAULT: hit = 1'b1;
			OP_AND3:    hit = c1Pass & c2Pass & c3Pass;
			OP_OR3:     hit = c1True | c2True | c3True;
			OP_AND2_OR: hit = (c1True & c2True) | c3True;
			OP_OR2_AND: hit = (c1True | c2True) & c3True;
			// undefined codes never select
			default:    hit = 1'b0;
		endcase
	end
endmodule

// ==== rtl/lbts_block_sel.sv ====
// priority pick of the first hitting slot of one logic block
`timescale 1ns/1ps
module lbts_block_sel
	import lbts_pkg::*;
(
	// slot results, slot A in bit 0
	input  wire logic [2:0] slotHit,
	// chosen slot index, 0 = A
	output logic [1:0]      selSlot
);
	always_comb begin
		// earlier slots shadow later ones; none hits means A
		if (slotHit[0]) begin
			selSlot = 2'h0;
		end else if (slotHit[1]) begin
			selSlot = 2'h1;
		end else if (slotHit[2]) begin
			selSlot = 2'h2;
		end else begin
			selSlot = 2'h0;
		end
	end
endmodule

// ==== tb/lbts_far_model.sv ====
// far-side stand-in: condition evaluators and lookup table units
`timescale 1ns/1ps
module lbts_far_model
	import lbts_pkg::*;
(
	// commands from the bench
	input  wire logic [35:0] condCmd,
	input  wire logic [5:0]  xCmd,
	input  wire logic [5:0]  vCmd,
	// towards the block
	output logic [35:0]      condResult,
	output logic [5:0]       ltXSrcSet,
	output logic [5:0]       ltRespValid,
	output logic [95:0]      ltYOut
);
	assign condResult  = condCmd;
	assign ltXSrcSet   = xCmd;
	assign ltRespValid = vCmd;

	// a table out of service shows garbage, so the block must not use it
	always_comb begin
		for (int t = 0; t < NUM_TABLES; t++) begin
			ltYOut[t*YOUT_W+:YOUT_W] = 16'(t * 100 + 105);
			if (!(xCmd[t] & vCmd[t])) begin
				ltYOut[t*YOUT_W+:YOUT_W] = ~16'(t * 100 + 105);
			end
		end
	end
endmodule

// ==== tb/tb_lbts_top.sv ====
// self-checking testbench for the logic block table selection
`timescale 1ns/1ps
module tb_lbts_top
	import lbts_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        rst_n   = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [35:0] condCmd = 36'h0;
	logic [5:0]  xCmd    = 6'h3F;
	logic [5:0]  vCmd    = 6'h3F;
	logic [31:0] prdata, rdData, lbOutValue;
	logic        pready, pslverr, errSeen;
	logic [35:0] condResult;
	logic [5:0]  ltXSrcSet, ltRespValid, lbSelTable;
	logic [95:0] ltYOut;
	logic [1:0]  lbNotAvail;
	int          errorCnt = 0;
	int          nChecks  = 0;
	logic [7:0]  ofs [5] = '{OFS_ENABLE, OFS_OPER1, OFS_OPER2,
		OFS_TABLE1, OFS_TABLE2};
	logic [31:0] rstVal [5] = '{32'h0, 32'h11, 32'h11, 32'h321, 32'h654};
	wire  [31:0] sel1 = {29'h0, lbSelTable[2:0]};
	wire  [31:0] out1 = {16'h0, lbOutValue[15:0]};
	wire  [31:0] na1  = {31'h0, lbNotAvail[0]};

	always #12.5 sys_clk = ~sys_clk;

	lbts_top lbts_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.condResult(condResult), .ltXSrcSet(ltXSrcSet),
		.ltRespValid(ltRespValid), .ltYOut(ltYOut), .lbOutValue(lbOutValue),
		.lbNotAvail(lbNotAvail), .lbSelTable(lbSelTable));

	lbts_far_model lbts_far_model_i (.condCmd(condCmd), .xCmd(xCmd),
		.vCmd(vCmd), .condResult(condResult), .ltXSrcSet(ltXSrcSet),
		.ltRespValid(ltRespValid), .ltYOut(ltYOut));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		nChecks++;
		if (seen !== exp) begin
			errorCnt++;
			$display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic completeRun;
		$display("checks %0d mismatches %0d", nChecks, errorCnt);
		if (errorCnt == 0 && nChecks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// no own limit: a slave that never answers is left to the watchdog
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rdData  = prdata;
		errSeen = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// outputs follow the far side one clock later
	task automatic drive(input logic [35:0] c, input logic [5:0] x,
		input logic [5:0] v);
		@(posedge sys_clk);
		condCmd <= c;
		xCmd    <= x;
		vCmd    <= v;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	function automatic logic exp_hit(input logic [2:0] op,
		input logic [5:0] c);
		logic [2:0] t;
		logic [2:0] n;
		for (int i = 0; i < 3; i++) begin
			t[i] = (c[2*i+:2] == COND_TRUE);
			n[i] = (c[2*i+:2] == COND_NA);
		end
		case (op)
			OP_DEFAULT: return 1'b1;
			OP_AND3:    return &(t | n);
			OP_OR3:     return |t;
			OP_AND2_OR: return (t[0] & t[1]) | t[2];
			OP_OR2_AND: return (t[0] | t[1]) & t[2];
			default:    return 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] yv(input logic [31:0] t);
		return t * 32'h64 + 32'h5;
	endfunction

	initial begin
		#(20000 * 25);
		errorCnt++;
		$display("[FAIL] %0t watchdog expired", $time);
		completeRun();
	end

	initial begin
		logic [31:0] tx;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1;
		check(32'(lbSelTable), 32'h0, "sel rst");
		check(32'(lbNotAvail), 32'h3, "na rst");
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ofs[i], 32'h0);
			check(rdData, rstVal[i], "reg rst");
			check({31'h0, errSeen}, 32'h0, "reg ok");
		end
		apb(1'b0, 8'h20, 32'h0);
		check({31'h0, errSeen}, 32'h1, "unmapped");
		check(rdData, 32'h0, "unmapped rd");
		apb(1'b1, OFS_SELECT, 32'h7);
		check({31'h0, errSeen}, 32'h1, "ro write");
		$display("test reset done");
		apb(1'b1, OFS_ENABLE, 32'h3);
		drive(36'h0, 6'h3F, 6'h3F);
		check(32'(lbSelTable), 32'h33, "dflt C");
		check({16'h0, lbOutValue[31:16]}, 32'h25D, "blk2 out");
		check(32'(lbNotAvail), 32'h0, "both avail");
		for (int op = 0; op < 6; op++) begin
			apb(1'b1, OFS_OPER1, 32'(op));
			for (int c = 0; c < 64; c++) begin
				drive(36'(c), 6'h3F, 6'h3F);
				tx = exp_hit(3'(op), 6'(c)) ? 32'h1 : 32'h2;
				check(sel1, tx, "s");
				check(out1, yv(tx), "o");
			end
		end
		$display("test operators done");
		apb(1'b1, OFS_OPER1, 32'h222);
		drive(36'h0, 6'h3F, 6'h3F);
		check(sel1, 32'h1, "fallback");
		drive(36'h1040, 6'h3F, 6'h3F);
		check(sel1, 32'h2, "B before C");
		apb(1'b1, OFS_TABLE1, 32'h465);
		drive(36'h0, 6'h3F, 6'h3F);
		check(sel1, 32'h5, "remap");
		apb(1'b0, OFS_SELECT, 32'h0);
		check(rdData, 32'h605, "sel reg");
		apb(1'b0, OFS_OUT1, 32'h0);
		check(rdData, 32'h1F9, "out reg");
		apb(1'b0, OFS_OUT2, 32'h0);
		check(rdData, 32'h25D, "out2 reg");
		$display("test selection done");
		drive(36'h0, 6'h2F, 6'h3F);
		check(na1, 32'h1, "no x");
		check(out1, 32'h0, "no x out");
		drive(36'h0, 6'h3F, 6'h2F);
		check(na1, 32'h1, "not valid");
		drive(36'h0, 6'h3F, 6'h3F);
		check(na1, 32'h0, "valid");
		apb(1'b1, OFS_ENABLE, 32'h2);
		drive(36'h0, 6'h3F, 6'h3F);
		check(32'(lbSelTable), 32'h30, "disabled");
		check(na1, 32'h1, "disabled na");
		$display("test output done");
		completeRun();
	end
endmodule
